// >>> src/pamc_defs.svh
//
// Functional notes
// - Live and running HVAC groups writable while running.
// - Stopped-only groups reject writes while running.
// - Monitor group is always read-only.
// - Lock 0: drive limited set, program all but monitor.
// - Lock 1: only speed setpoints writable.
// - Drive: system/control visible only reset+display.
// - Drive: group four read-only except fifth entry.
// - Mode key acts only while stopped.
// - Motor runs only in drive mode.
// - Local: keypad sources, both source LEDs off.
// - Remote: run source per select, LED on.
// - Remote: frequency source per select, LED on.
// - Key function 1: local key acts as jog in drive mode only.
// - Key function 0: local key toggles remote.
// - Power-up enters drive mode directly.
`ifndef PAMC_DEFS_SVH
`define PAMC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PAMC_CFG_OFS      12'h000
`define PAMC_STAT_OFS     12'h004

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PAMC_CFG_LOCK_BIT  0
`define PAMC_CFG_RUN_LSB   4
`define PAMC_CFG_FREQ_LSB  8
`define PAMC_CFG_KEYFN_BIT 12
`define PAMC_ST_PROG_BIT   0
`define PAMC_ST_REM_BIT    1
`define PAMC_ST_RUN_BIT    2
`define PAMC_ST_DRV_BIT    3

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define PAMC_LOCK_RST      1'b0
`define PAMC_SEL_RST       2'h0
`define PAMC_KEYFN_RST     1'b0
`define PAMC_SEL_TERMINAL  2'h1
`define PAMC_SEL_SERIAL    2'h2
`define PAMC_FIFTH_ENTRY   8'h05

// ----------------------------------------------------------------
// Key pin positions
// ----------------------------------------------------------------
`define PAMC_KEY_MODE      0
`define PAMC_KEY_LOCAL     1
`define PAMC_KEY_RESET     2
`define PAMC_KEY_DISPLAY   3

`endif

// >>> src/pamc_pkg.sv
package pamc_pkg;

  // Parameter groups as seen by the parameter store.
  typedef enum logic [3:0] {
    speed_setpoint_group,
    live_tunable_group,
    system_setting_group,
    control_param_group,
    hvac_stopped_group_one,
    hvac_running_group_two,
    hvac_stopped_group_three,
    hvac_stopped_group_four,
    hvac_running_group_five,
    monitor_group
  } pamc_group_type;

  // Where a run or frequency command comes from.
  typedef enum logic [1:0] {
    src_keypad,
    src_terminal,
    src_serial
  } pamc_src_type;

  // Access request from the keypad editor.
  typedef struct packed {
    logic           valid;
    logic           write;
    pamc_group_type group;
    logic [7:0]     entry;
  } pamc_acc_req_type;

  // Answer to an access request.
  typedef struct packed {
    logic done;
    logic granted;
  } pamc_acc_rsp_type;

  // Command source selection and indicators.
  typedef struct packed {
    pamc_src_type run_src;
    pamc_src_type freq_src;
    logic         run_source_led;
    logic         freq_source_led;
  } pamc_route_type;

endpackage : pamc_pkg

// >>> src/pamc_top.sv
`timescale 1ns/1ns
`include "pamc_defs.svh"

module pamc_top (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  input  wire logic                      hsel,
  input  wire logic [11:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic [3:0]                key_pins,
  input  wire logic                      motor_running,
  input  wire pamc_pkg::pamc_acc_req_type acc_req,
  output pamc_pkg::pamc_acc_rsp_type     acc_rsp,
  output pamc_pkg::pamc_route_type       route,
  output logic                           program_mode,
  output logic                           drive_enable,
  output logic                           jog_pulse
);
  import pamc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]       key_s1;
    logic [3:0]       key_s2;
    logic [3:0]       key_p;
    logic             lock;
    logic [1:0]       run_sel;
    logic [1:0]       freq_sel;
    logic             key_fn;
    logic             prog;
    logic             remote;
    logic             drv_en;
    logic             jog;
    pamc_acc_rsp_type rsp;
    pamc_route_type   rt;
    logic             ap_wr;
    logic [11:0]      ap_addr;
    logic [31:0]      rdata;
  } pamc_state_type;

  pamc_state_type q;
  pamc_state_type d;

  logic [3:0] key_edge;
  logic       ap_valid;
  logic       may_write;
  logic       may_view;

  // ----------------------------------------------------------------
  // Permission decode
  // ----------------------------------------------------------------

  // Write permission for one group and entry in the present state.
  function automatic logic pamc_writable(
    input pamc_group_type grp,
    input logic [7:0]     ent,
    input logic           prog,
    input logic           lock,
    input logic           run
  );
    logic ok;
    ok = 1'b0;
    if (lock) begin
      ok = (grp == speed_setpoint_group);
    end else if (prog) begin
      unique case (grp)
        speed_setpoint_group,
        live_tunable_group,
        hvac_running_group_two,
        hvac_running_group_five: ok = 1'b1;
        system_setting_group,
        control_param_group,
        hvac_stopped_group_one,
        hvac_stopped_group_three,
        hvac_stopped_group_four: ok = !run;
        monitor_group:           ok = 1'b0;
        default:                 ok = 1'b0;
      endcase
    end else begin
      unique case (grp)
        speed_setpoint_group,
        live_tunable_group,
        hvac_running_group_two,
        hvac_running_group_five: ok = 1'b1;
        // The fifth entry stays a stopped-only setting even in drive mode.
        hvac_stopped_group_four: ok = (ent == `PAMC_FIFTH_ENTRY) && !run;
        default:                 ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : pamc_writable

  // Display permission; system and control need both keys in drive mode.
  function automatic logic pamc_viewable(
    input pamc_group_type grp,
    input logic           prog,
    input logic           combo
  );
    logic ok;
    ok = 1'b1;
    if (!prog && (grp == system_setting_group || grp == control_param_group)) begin
      ok = combo;
    end
    if (grp > monitor_group) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : pamc_viewable

  assign may_write = pamc_writable(acc_req.group, acc_req.entry, q.prog, q.lock,
                                   motor_running);
  assign may_view  = pamc_viewable(acc_req.group, q.prog,
                                   q.key_s2[`PAMC_KEY_RESET] &
                                   q.key_s2[`PAMC_KEY_DISPLAY]);

  // Rising edges look only at the second and third stages.
  assign key_edge = q.key_s2 & ~q.key_p;
  assign ap_valid = hsel & htrans[1] & hready;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // All state advances from one copy so that every output but hreadyout and hresp is a flop.
  always_comb begin
    d = q;

    // Key pins arrive from the membrane keypad, outside this clock.
    d.key_s1 = key_pins;
    d.key_s2 = q.key_s1;
    d.key_p  = q.key_s2;

    // A press while the motor turns is dropped, not remembered.
    if (key_edge[`PAMC_KEY_MODE] && !motor_running) begin
      d.prog = !q.prog;
    end

    // The local key is either a source toggle or a jog key.
    d.jog = 1'b0;
    if (key_edge[`PAMC_KEY_LOCAL]) begin
      if (q.key_fn) begin
        d.jog = !q.prog;
      end else begin
        d.remote = !q.remote;
      end
    end

    // Drive operation only outside program mode.
    d.drv_en = !d.prog;

    // Source routing and indicators follow the local or remote state.
    if (!d.remote) begin
      d.rt.run_src         = src_keypad;
      d.rt.freq_src        = src_keypad;
      d.rt.run_source_led  = 1'b0;
      d.rt.freq_source_led = 1'b0;
    end else begin
      d.rt.run_source_led  = 1'b1;
      d.rt.freq_source_led = 1'b1;
      unique case (q.run_sel)
        `PAMC_SEL_TERMINAL: d.rt.run_src = src_terminal;
        `PAMC_SEL_SERIAL:   d.rt.run_src = src_serial;
        default:            d.rt.run_src = src_keypad;
      endcase
      unique case (q.freq_sel)
        `PAMC_SEL_TERMINAL: d.rt.freq_src = src_terminal;
        `PAMC_SEL_SERIAL:   d.rt.freq_src = src_serial;
        default:            d.rt.freq_src = src_keypad;
      endcase
    end

    // Each request taken with clk_en high is answered one cycle later; a refusal stores nothing.
    d.rsp.done    = acc_req.valid;
    d.rsp.granted = acc_req.valid &
                    (acc_req.write ? may_write : may_view);

    // Bus data phase: configuration write lands here.
    if (q.ap_wr && q.ap_addr == `PAMC_CFG_OFS) begin
      d.lock     = hwdata[`PAMC_CFG_LOCK_BIT];
      d.run_sel  = hwdata[`PAMC_CFG_RUN_LSB +: 2];
      d.freq_sel = hwdata[`PAMC_CFG_FREQ_LSB +: 2];
      d.key_fn   = hwdata[`PAMC_CFG_KEYFN_BIT];
    end

    // Bus address phase; read data uses the updated copy so a read
    // right after a write sees the new value.
    d.ap_wr = 1'b0;
    if (ap_valid) begin
      d.ap_wr   = hwrite;
      d.ap_addr = {haddr[11:2], 2'b00};
      d.rdata   = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr[11:2] == `PAMC_CFG_OFS >> 2) begin
          d.rdata[`PAMC_CFG_LOCK_BIT]       = d.lock;
          d.rdata[`PAMC_CFG_RUN_LSB +: 2]   = d.run_sel;
          d.rdata[`PAMC_CFG_FREQ_LSB +: 2]  = d.freq_sel;
          d.rdata[`PAMC_CFG_KEYFN_BIT]      = d.key_fn;
        end else if (haddr[11:2] == `PAMC_STAT_OFS >> 2) begin
          d.rdata[`PAMC_ST_PROG_BIT] = q.prog;
          d.rdata[`PAMC_ST_REM_BIT]  = q.remote;
          d.rdata[`PAMC_ST_RUN_BIT]  = motor_running;
          d.rdata[`PAMC_ST_DRV_BIT]  = q.drv_en;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Power-up lands in drive mode, local sources, lock open.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.lock     <= `PAMC_LOCK_RST;
      q.run_sel  <= `PAMC_SEL_RST;
      q.freq_sel <= `PAMC_SEL_RST;
      q.key_fn   <= `PAMC_KEYFN_RST;
      q.prog     <= 1'b0;
      q.drv_en   <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // The slave never stalls and never errors, so ready stays high.
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = q.rdata;
  assign acc_rsp      = q.rsp;
  assign route        = q.rt;
  assign program_mode = q.prog;
  assign drive_enable = q.drv_en;
  assign jog_pulse    = q.jog;

endmodule : pamc_top

// >>> tb/pamc_top_monitor.sv
`timescale 1ns/1ns
module pamc_top_monitor (
  input wire logic                       core_clk,
  input wire logic                       rstn,
  input wire logic                       clk_en,
  input wire logic                       motor_running,
  input wire pamc_pkg::pamc_acc_req_type acc_req,
  input wire pamc_pkg::pamc_acc_rsp_type acc_rsp,
  input wire pamc_pkg::pamc_route_type   route,
  input wire logic                       program_mode,
  input wire logic                       drive_enable,
  input wire logic                       jog_pulse
);
  import pamc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Stability is checked only from the sixth running cycle on, so a flip in the first five running cycles is not seen.
  sequence running_long;
    motor_running [*6];
  endsequence
  sequence write_req;
    clk_en && acc_req.valid && acc_req.write;
  endsequence

  a_done_next: assert property (clk_en && acc_req.valid |=> acc_rsp.done)
    else $error("access answer missing");
  a_grant_with_done: assert property (acc_rsp.granted |-> acc_rsp.done)
    else $error("grant without answer");
  a_monitor_readonly: assert property (write_req ##0 acc_req.group == monitor_group
    |=> !acc_rsp.granted) else $error("monitor write granted");
  a_stopped_groups: assert property (write_req ##0 motor_running && acc_req.group inside
    {system_setting_group, control_param_group, hvac_stopped_group_one,
     hvac_stopped_group_three, hvac_stopped_group_four} |=> !acc_rsp.granted)
    else $error("stopped group written while running");
  a_drive_limited: assert property (write_req ##0 !program_mode && acc_req.group inside
    {system_setting_group, control_param_group, hvac_stopped_group_one,
     hvac_stopped_group_three} |=> !acc_rsp.granted) else $error("drive mode write granted");
  a_drive_enable: assert property ($stable(program_mode) |-> drive_enable != program_mode)
    else $error("drive enable disagrees with mode");
  a_mode_hold: assert property (running_long |-> $stable(program_mode))
    else $error("mode changed while running");
  a_led_pair: assert property (route.run_source_led == route.freq_source_led)
    else $error("source leds differ");
  a_local_keypad: assert property (!route.run_source_led |->
    route.run_src == src_keypad && route.freq_src == src_keypad) else $error("local not keypad");
  a_jog_single: assert property (jog_pulse |-> !program_mode ##1 !jog_pulse)
    else $error("jog pulse wrong");
endmodule : pamc_top_monitor

bind pamc_top pamc_top_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
  .motor_running(motor_running), .acc_req(acc_req), .acc_rsp(acc_rsp), .route(route),
  .program_mode(program_mode), .drive_enable(drive_enable), .jog_pulse(jog_pulse));

// >>> tb/pamc_keypad.sv
`timescale 1ns/1ns
module pamc_keypad (
  input wire logic core_clk,
  output logic [3:0] key_pins
);
  initial key_pins = 4'h0;

  // A press is held past the synchroniser and released, so the next one is a fresh edge.
  task automatic press(input int k);
    hold(k, 1'b1);
    hold(k, 1'b0);
  endtask : press

  // Keys held together for a combined function are set one level at a time.
  task automatic hold(input int k, input logic v);
    @(posedge core_clk);
    key_pins[k] <= v;
    repeat (6) @(posedge core_clk);
  endtask : hold
endmodule : pamc_keypad

// >>> tb/pamc_tb.sv
`timescale 1ns/1ns
`include "pamc_defs.svh"
module pamc_tb;
  import pamc_pkg::*;
  logic             core_clk = 1'b0;
  logic             rstn = 1'b0;
  logic             clk_en = 1'b1;
  logic             hsel = 1'b0;
  logic [11:0]      haddr = 12'h000;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic             motor_running = 1'b0;
  pamc_acc_req_type acc_req = '0;
  pamc_acc_rsp_type acc_rsp;
  pamc_route_type   route;
  logic [31:0]      hrdata, rd;
  logic [3:0]       key_pins;
  logic             hreadyout, hresp, program_mode, drive_enable, jog_pulse;
  int               failures = 0;
  int               checks = 0;
  int               jogs = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) jogs <= jogs + int'(jog_pulse === 1'b1);

  pamc_top uut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_pins(key_pins),
    .motor_running(motor_running), .acc_req(acc_req), .acc_rsp(acc_rsp), .route(route),
    .program_mode(program_mode), .drive_enable(drive_enable), .jog_pulse(jog_pulse));
  pamc_keypad kp (.core_clk(core_clk), .key_pins(key_pins));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Single word transfer; the wait loops never assume a latency.
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task acc(input logic wr, input int g, input logic [7:0] e, input logic exp);
    @(posedge core_clk);
    acc_req <= '{1'b1, wr, pamc_group_type'(g), e};
    @(posedge core_clk);
    acc_req <= '0;
    #1;
    chk("done", 32'(acc_rsp.done), 32'h1);
    chk("granted", 32'(acc_rsp.granted), 32'(exp));
  endtask : acc

  // Mask bit g is the expected grant for group g.
  task sweep(input logic [9:0] m, input logic [7:0] e);
    for (int g = 0; g < 10; g++) begin
      acc(1'b1, g, e, m[g]);
    end
  endtask : sweep

  task motor(input logic v);
    @(posedge core_clk);
    motor_running <= v;
  endtask : motor

  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("mode", 32'(program_mode), 32'h0);
    chk("drive", 32'(drive_enable), 32'h1);
    chk("route", 32'(route), 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    bus(1'b0, `PAMC_CFG_OFS, 32'h0);
    chk("cfg", rd, 32'h0);
    $display("test reset finished");
    sweep(10'h123, 8'h04);
    acc(1'b1, hvac_stopped_group_four, `PAMC_FIFTH_ENTRY, 1'b1);
    acc(1'b0, system_setting_group, 8'h01, 1'b0);
    kp.hold(`PAMC_KEY_RESET, 1'b1);
    kp.hold(`PAMC_KEY_DISPLAY, 1'b1);
    acc(1'b0, control_param_group, 8'h01, 1'b1);
    acc(1'b1, control_param_group, 8'h01, 1'b0);
    kp.hold(`PAMC_KEY_RESET, 1'b0);
    kp.hold(`PAMC_KEY_DISPLAY, 1'b0);
    motor(1'b1);
    sweep(10'h123, `PAMC_FIFTH_ENTRY);
    kp.press(`PAMC_KEY_MODE);
    motor(1'b0);
    repeat (8) @(posedge core_clk);
    chk("mode", 32'(program_mode), 32'h0);
    $display("test drive mode finished");
    kp.press(`PAMC_KEY_MODE);
    chk("mode", 32'(program_mode), 32'h1);
    chk("drive", 32'(drive_enable), 32'h0);
    bus(1'b0, `PAMC_STAT_OFS, 32'h0);
    chk("status", rd, 32'h1);
    sweep(10'h1ff, 8'h04);
    motor(1'b1);
    sweep(10'h123, 8'h04);
    motor(1'b0);
    bus(1'b1, `PAMC_CFG_OFS, 32'h1);
    sweep(10'h001, 8'h04);
    kp.press(`PAMC_KEY_MODE);
    sweep(10'h001, 8'h04);
    bus(1'b1, 12'h008, 32'hffff_ffff);
    bus(1'b0, 12'h008, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test lock finished");
    bus(1'b1, `PAMC_CFG_OFS, 32'h0000_0210);
    kp.press(`PAMC_KEY_LOCAL);
    chk("route", 32'(route), 32'h1b);
    bus(1'b1, `PAMC_CFG_OFS, 32'h0000_0120);
    repeat (2) @(posedge core_clk);
    chk("route", 32'(route), 32'h27);
    kp.press(`PAMC_KEY_LOCAL);
    chk("route", 32'(route), 32'h0);
    bus(1'b1, `PAMC_CFG_OFS, 32'h0000_1000);
    kp.press(`PAMC_KEY_LOCAL);
    chk("jogs", 32'(jogs), 32'h1);
    chk("route", 32'(route), 32'h0);
    // A request that meets a low clock enable must leave no answer behind.
    @(posedge core_clk);
    clk_en <= 1'b0;
    acc_req <= '{1'b1, 1'b1, speed_setpoint_group, 8'h01};
    @(posedge core_clk);
    acc_req <= '0;
    clk_en <= 1'b1;
    #1;
    chk("frozen", 32'(acc_rsp.done), 32'h0);
    $display("test sources finished");
    summarize();
  end

  // The tests need well under ten thousand cycles.
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule : pamc_tb
